// [scrb_gpi_model.sv]
// Purpose: Far-side model driving the general input pins
// Assumes: Pins are asynchronous to the device clock
// Notes: Changes land mid-cycle so the synchroniser sees them cleanly
`timescale 1ns/10ps
module scrb_gpi_model (
  // Commanded levels
  input wire logic [2:0] level_in,
  // Pins
  output logic [2:0] pin_out
);
  // Skewed copy, never on a clock edge
  initial pin_out = 3'h0;
  always @(level_in) pin_out <= #1.3 level_in;
endmodule : scrb_gpi_model

// [scrb_pkg.sv]
// Purpose: Constants for the supply control register bank
// Assumes: Byte-wide registers at the printed byte offsets
// Notes:   Supply index 0..3 = second buck, third buck, first linreg, second linreg
package scrb_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] THIRD_BUCK_CONTROL_ADDR = 8'h22;
  localparam logic [7:0] SECOND_BUCK_CONTROL_ADDR = 8'h24;
  localparam logic [7:0] FIRST_LDO_CONTROL_ADDR = 8'h26;
  localparam logic [7:0] SECOND_LDO_CONTROL_ADDR = 8'h27;
  localparam logic [7:0] VOLTAGE_SELECT_ADDR = 8'h32;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ON_REQUEST_BIT = 0;
  localparam int ENABLE_SOURCE_LO = 1;
  localparam int PULLDOWN_OFF_BIT = 3;
  localparam int BUCK_FLAG_BIT = 3;
  localparam int LINREG_FLAG_BIT = 7;
  localparam int VOLTAGE_SOURCE_LO = 5;
  // Writable bits; everything else is reserved and reads zero
  localparam logic [7:0] BUCK_WRITE_MASK = 8'h6f;
  localparam logic [7:0] LINREG_WRITE_MASK = 8'hef;
  // Bit of each supply inside the voltage select register
  localparam int SEL_BIT_SECOND_BUCK = 3;
  localparam int SEL_BIT_THIRD_BUCK = 2;
  localparam int SEL_BIT_FIRST_LINREG = 4;
  localparam int SEL_BIT_SECOND_LINREG = 5;

  // ----------------------------------------------------------------
  // Encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] SOURCE_SEQUENCER = 2'h0;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam int NUM_SUPPLIES = 4;
  localparam int NUM_BUCKS = 2;
  localparam int NUM_INPUTS = 3;

endpackage : scrb_pkg

// [scrb_supply_control.sv]
// Purpose: Control registers for two buck converters and two linear regulators
// Assumes: Register port driven by the serial interface logic on sys_clk_in
// Notes:   Outputs are registered; general inputs are synchronised first
//          Input and sequencer edges override a software write made in the same cycle
`timescale 1ns/10ps
module scrb_supply_control (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // General inputs (pins) and their active level (same clock)
  input wire logic [2:0] general_input_in,
  input wire logic [2:0] general_active_high_in,
  // Sequencer requests per supply (same clock)
  input wire logic [3:0] seq_on_in,
  input wire logic [3:0] seq_volt_b_in,
  // Supply controls
  output logic [3:0] supply_on_out,
  output logic [3:0] volt_b_out,
  output logic [3:0] sequencing_flag_out,
  output logic [1:0] pulldown_on_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // All registers of the block live in one packed struct so that the
  // reset, the next-state copy and the output taps stay in step
  typedef struct packed {
    logic [3:0][7:0] ctrl;
    logic [3:0] sel;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] prev;
    logic [3:0] seq_on_prev;
    logic [7:0] rdata;
    logic rvalid;
    logic [3:0] on;
    logic [3:0] volt_b;
    logic [3:0] flag;
    logic [1:0] pd;
  } scrb_state_t;

  // Current and next copy of the whole state
  scrb_state_t state_q;
  scrb_state_t state_d;

  // Map a supply index to its address and select bit
  // An unmapped address matches no supply, so a write to it is dropped
  function automatic logic [7:0] supply_addr(input int idx);
    case (idx)
      0: supply_addr = scrb_pkg::SECOND_BUCK_CONTROL_ADDR;
      1: supply_addr = scrb_pkg::THIRD_BUCK_CONTROL_ADDR;
      2: supply_addr = scrb_pkg::FIRST_LDO_CONTROL_ADDR;
      default: supply_addr = scrb_pkg::SECOND_LDO_CONTROL_ADDR;
    endcase
  endfunction : supply_addr

  // Bit of each supply inside the voltage select register
  function automatic int sel_bit(input int idx);
    case (idx)
      0: sel_bit = scrb_pkg::SEL_BIT_SECOND_BUCK;
      1: sel_bit = scrb_pkg::SEL_BIT_THIRD_BUCK;
      2: sel_bit = scrb_pkg::SEL_BIT_FIRST_LINREG;
      default: sel_bit = scrb_pkg::SEL_BIT_SECOND_LINREG;
    endcase
  endfunction : sel_bit

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [2:0] act;
    logic [2:0] rise;
    logic [2:0] fall;
    logic [1:0] esrc;
    logic [1:0] vsrc;
    logic [7:0] mask;
    logic [7:0] cur;
    logic [7:0] sel_reg;
    logic is_buck;
    // Every local gets a value first, so no path leaves a latch behind
    act = 3'h0;
    rise = 3'h0;
    fall = 3'h0;
    esrc = scrb_pkg::SOURCE_SEQUENCER;
    vsrc = scrb_pkg::SOURCE_SEQUENCER;
    mask = scrb_pkg::READ_ZERO;
    cur = scrb_pkg::READ_ZERO;
    sel_reg = scrb_pkg::READ_ZERO;
    is_buck = 1'b0;
    state_d = state_q;
    // Pins pass two flops before any logic reads them
    state_d.sync1 = general_input_in;
    state_d.sync2 = state_q.sync1;
    // Active when the synchronised level equals the input's active level
    act = ~(state_q.sync2 ^ general_active_high_in);
    state_d.prev = act;
    rise = act & ~state_q.prev;
    fall = ~act & state_q.prev;
    // Sequencer requests share our clock, so one flop of history finds edges
    state_d.seq_on_prev = seq_on_in;
    // Voltage select register view of the per-supply select bits
    sel_reg = scrb_pkg::READ_ZERO;
    for (int i = 0; i < scrb_pkg::NUM_SUPPLIES; i++) begin
      sel_reg[sel_bit(i)] = state_q.sel[i];
    end
    // Registered read; unmapped offsets read zero
    // A read and a write in one cycle return the value from before the write
    state_d.rvalid = reg_rd_in;
    state_d.rdata = state_q.rdata;
    if (reg_rd_in) begin
      state_d.rdata = scrb_pkg::READ_ZERO;
      if (reg_addr_in == scrb_pkg::VOLTAGE_SELECT_ADDR) begin
        state_d.rdata = sel_reg;
      end
    end
    for (int i = 0; i < scrb_pkg::NUM_SUPPLIES; i++) begin
      // Supplies 0 and 1 are bucks, 2 and 3 linear regulators
      is_buck = (i < scrb_pkg::NUM_BUCKS);
      mask = is_buck ? scrb_pkg::BUCK_WRITE_MASK : scrb_pkg::LINREG_WRITE_MASK;
      cur = state_q.ctrl[i];
      if (reg_rd_in && reg_addr_in == supply_addr(i)) begin
        state_d.rdata = cur & mask;
      end
      // Software writes touch writable bits only
      // A same-cycle input or sequencer edge still rewrites the on-request below
      if (reg_wr_in && reg_addr_in == supply_addr(i)) begin
        cur = reg_wdata_in & mask;
      end
      if (reg_wr_in && reg_addr_in == scrb_pkg::VOLTAGE_SELECT_ADDR) begin
        state_d.sel[i] = reg_wdata_in[sel_bit(i)];
      end
      // Codes 01..11 index the edge vectors one below the code; code 00
      // never reaches that index, so no out-of-range bit is read
      esrc = state_q.ctrl[i][scrb_pkg::ENABLE_SOURCE_LO +: 2];
      vsrc = state_q.ctrl[i][scrb_pkg::VOLTAGE_SOURCE_LO +: 2];
      // Hardware edges update the on-request after the write, so an edge wins
      if (esrc == scrb_pkg::SOURCE_SEQUENCER) begin
        if (seq_on_in[i] && !state_q.seq_on_prev[i]) begin
          cur[scrb_pkg::ON_REQUEST_BIT] = 1'b1;
        end else if (!seq_on_in[i] && state_q.seq_on_prev[i]) begin
          cur[scrb_pkg::ON_REQUEST_BIT] = 1'b0;
        end
      end else if (rise[esrc - 2'h1]) begin
        cur[scrb_pkg::ON_REQUEST_BIT] = 1'b1;
      end else if (fall[esrc - 2'h1]) begin
        cur[scrb_pkg::ON_REQUEST_BIT] = 1'b0;
      end
      state_d.ctrl[i] = cur;
      // Input edges move the voltage choice; sequencer code follows the sequencer
      if (vsrc == scrb_pkg::SOURCE_SEQUENCER) begin
        // Either the sequencer or the software select can ask for setting B
        state_d.volt_b[i] = seq_volt_b_in[i] | state_q.sel[i];
      end else if (rise[vsrc - 2'h1]) begin
        state_d.sel[i] = 1'b0;
        state_d.volt_b[i] = 1'b0;
      end else if (fall[vsrc - 2'h1]) begin
        state_d.sel[i] = 1'b1;
        state_d.volt_b[i] = 1'b1;
      end else begin
        // No edge this cycle: follow the software select, which edges also rewrite
        state_d.volt_b[i] = state_q.sel[i];
      end
      // The on-request is the final word after sequencer and input edges
      if (is_buck) begin
        state_d.on[i] = cur[scrb_pkg::ON_REQUEST_BIT];
        state_d.flag[i] = cur[scrb_pkg::BUCK_FLAG_BIT];
      end else begin
        state_d.on[i] = cur[scrb_pkg::ON_REQUEST_BIT];
        state_d.flag[i] = cur[scrb_pkg::LINREG_FLAG_BIT];
      end
    end
    // Pull-down only while off, and only if not disabled; it reads the next
    // control value so that it moves at the same edge as the on-request
    for (int j = 0; j < scrb_pkg::NUM_SUPPLIES - scrb_pkg::NUM_BUCKS; j++) begin
      state_d.pd[j] = !state_d.ctrl[j + scrb_pkg::NUM_BUCKS][scrb_pkg::ON_REQUEST_BIT]
          && !state_d.ctrl[j + scrb_pkg::NUM_BUCKS][scrb_pkg::PULLDOWN_OFF_BIT];
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Synchronous reset loads constants only
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      // Every field to zero first, then the fields with other reset values
      state_q <= '0;
      for (int i = 0; i < scrb_pkg::NUM_SUPPLIES; i++) begin
        state_q.ctrl[i] <= scrb_pkg::CONTROL_RESET;
      end
      state_q.pd <= 2'h3; // Both regulators start off with pull-down active
    end else begin
      state_q <= state_d;
    end
  end

  // Outputs straight from flops
  // No logic sits between a flop and a pin, so outputs never glitch
  assign reg_rdata_out = state_q.rdata;
  assign reg_rvalid_out = state_q.rvalid;
  assign supply_on_out = state_q.on;
  assign volt_b_out = state_q.volt_b;
  assign sequencing_flag_out = state_q.flag;
  assign pulldown_on_out = state_q.pd;

endmodule : scrb_supply_control

// [scrb_sva.sv]
// Purpose: Port assertions for the supply control bank
// Assumes: Bench keeps input edges away from checked writes
// Notes: Bound to the design at the foot of this file
`timescale 1ns/10ps
module scrb_sva (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  // Supply side
  input wire logic [3:0] seq_on_in,
  input wire logic [3:0] seq_volt_b_in,
  input wire logic [3:0] supply_on_out,
  input wire logic [3:0] volt_b_out,
  input wire logic [3:0] sequencing_flag_out,
  input wire logic [1:0] pulldown_on_out
);
  // ----
  // Checks
  // ----
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_read_answer: assert property (reg_rd_in |=> reg_rvalid_out)
    else $error("read without answer");
  a_read_quiet: assert property (!reg_rd_in |=> !reg_rvalid_out)
    else $error("answer without read");
  a_unmapped_zero: assert property (reg_rd_in && reg_addr_in[7:6] != 2'h0
    |=> reg_rdata_out == 8'h00) else $error("unmapped read not zero");
  a_buck_reserved: assert property (reg_rd_in && reg_addr_in == 8'h24
    |=> reg_rdata_out[7] == 1'b0 && reg_rdata_out[4] == 1'b0) else $error("buck reserved set");
  a_linreg_reserved: assert property (reg_rd_in && reg_addr_in == 8'h27
    |=> reg_rdata_out[4] == 1'b0) else $error("linreg reserved set");
  a_buck_write: assert property (reg_wr_in && reg_addr_in == 8'h24 && $stable(seq_on_in)
    |=> supply_on_out[0] == $past(reg_wdata_in[0])
    && sequencing_flag_out[0] == $past(reg_wdata_in[3])) else $error("buck write lost");
  a_linreg_write: assert property (reg_wr_in && reg_addr_in == 8'h26 && $stable(seq_on_in)
    |=> supply_on_out[2] == $past(reg_wdata_in[0]) && sequencing_flag_out[2] == $past(reg_wdata_in[7])
    && pulldown_on_out[0] == !($past(reg_wdata_in[0]) || $past(reg_wdata_in[3])))
    else $error("linreg write lost");
  a_select_volt: assert property (reg_wr_in && reg_addr_in == 8'h32 && seq_volt_b_in == 4'h0
    |=> ##1 volt_b_out[0] == $past(reg_wdata_in[3], 2)) else $error("select not applied");
  cover property (reg_rd_in ##1 reg_rvalid_out);
  cover property ($rose(supply_on_out[1]));
  cover property ($rose(volt_b_out[3]));
endmodule : scrb_sva
bind scrb_supply_control scrb_sva scrb_sva_inst (.*);

// [tb.sv]
// Purpose: Register and input-edge tests of the supply control bank
// Assumes: Inputs active high except in one late test; input edges 3 clocks to output
// Notes: Sequencer inputs idle except in their own test
`timescale 1ns/10ps
module tb;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wd = 8'h00;
  logic [7:0] rdata;
  logic rv;
  logic [2:0] lvl = 3'h0;
  logic [2:0] pins;
  logic [2:0] ah = 3'h7;
  logic [3:0] son = 4'h0;
  logic [3:0] svb = 4'h0;
  logic [3:0] on, vb, fl;
  logic [1:0] pd;
  int errors = 0;
  int checks_done = 0;
  // ----
  // Harness
  // ----
  initial forever #2 sys_clk_in = ~sys_clk_in;
  scrb_gpi_model scrb_gpi_model_inst (.level_in(lvl), .pin_out(pins));
  scrb_supply_control scrb_supply_control_inst (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wd),
    .reg_rdata_out(rdata), .reg_rvalid_out(rv), .general_input_in(pins),
    .general_active_high_in(ah), .seq_on_in(son), .seq_volt_b_in(svb),
    .supply_on_out(on), .volt_b_out(vb), .sequencing_flag_out(fl), .pulldown_on_out(pd));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // Strobes rise after an edge and drop after the taking edge
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge sys_clk_in);
    wr <= 1'b0;
    #1;
  endtask : wrr
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk_in);
    rd <= 1'b1;
    addr <= a;
    @(posedge sys_clk_in);
    rd <= 1'b0;
    #1;
    chk({7'h00, rv}, 8'h01);
    chk(rdata, e);
  endtask : rdc
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask : wt
  task automatic summarize;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize
  // Main sequence
  initial begin
    repeat (2) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    wt(1);
    chk({6'h00, pd}, 8'h03);
    rdc(8'h24, 8'h00);
    wrr(8'h24, 8'hff);
    chk({on, fl}, 8'h11);
    rdc(8'h24, 8'h6f);
    wrr(8'h24, 8'h00);
    wrr(8'h26, 8'hff);
    rdc(8'h26, 8'hef);
    chk({on, fl}, 8'h44);
    chk({6'h00, pd}, 8'h02);
    wrr(8'h26, 8'h08);
    chk({2'h0, on, pd}, 8'h02);
    // Each input in turn drives enable and voltage of the third buck
    for (int s = 1; s <= 3; s++) begin
      wrr(8'h22, {1'b0, s[1:0], 2'h0, s[1:0], 1'b0});
      @(posedge sys_clk_in);
      lvl[s-1] <= 1'b1;
      wt(3);
      chk({6'h00, on[1], vb[1]}, 8'h02);
      @(posedge sys_clk_in);
      lvl[s-1] <= 1'b0;
      wt(3);
      chk({6'h00, on[1], vb[1]}, 8'h01);
    end
    // Input one active low: a high pin is a release, a low pin a press
    @(posedge sys_clk_in);
    ah <= 3'h6;
    wrr(8'h22, 8'h22);
    @(posedge sys_clk_in);
    lvl[0] <= 1'b1;
    wt(3);
    chk({6'h00, on[1], vb[1]}, 8'h01);
    @(posedge sys_clk_in);
    lvl[0] <= 1'b0;
    wt(3);
    chk({6'h00, on[1], vb[1]}, 8'h02);
    @(posedge sys_clk_in);
    son <= 4'h8;
    svb <= 4'h8;
    wt(3);
    chk({on[3], vb[3]}, 8'h03);
    @(posedge sys_clk_in);
    svb <= 4'h0;
    wrr(8'h32, 8'h20);
    wt(1);
    chk({vb[3], vb[0]}, 8'h02);
    wrr(8'h32, 8'hff);
    rdc(8'h32, 8'h3c);
    rdc(8'h40, 8'h00);
    summarize();
  end
  // Watchdog well beyond the 72 cycles of the tests
  initial begin
    repeat (3000) @(posedge sys_clk_in);
    errors++;
    summarize();
  end
endmodule : tb
